// file: verilog/gpsb_pkg.sv
// Shared constants and types for the general pin and strap block
//==============================================================
// Behaviour
// - Each pin: input, edge interrupt, or output
// - Strap pull-up on while reset held
// - Strap pull-up off cycles after release
// - Strap level captured at reset release
// - Strap high or floating selects internal memory
// - Strap pin is ordinary pin once the strap pull-up is off
// - Stick serial clock with programmable divider
// - Card bus clock, independently configurable
// - Stick insertion sampled, presence reported
package gpsb_pkg;

  //==============================================================
  // Pin layout and timing
  localparam int GPSB_NUM_PINS = 8;
  localparam int GPSB_STRAP_IDX = 6;
  localparam int GPSB_PU_HOLD_CYC = 4;
  localparam int GPSB_PU_CNT_W = 3;
  localparam int GPSB_DIV_W = 8;

  // Reset and end values
  localparam logic GPSB_STRAP_RST = 1'b1;
  localparam logic [GPSB_PU_CNT_W-1:0] GPSB_PU_CNT_RST = 3'h0;
  localparam logic [GPSB_PU_CNT_W-1:0] GPSB_PU_CNT_END = 3'h4;

  //==============================================================
  // Pin modes
  typedef enum logic [1:0] {
    GPSB_MODE_INPUT = 2'b00,
    GPSB_MODE_EDGE_IRQ = 2'b01,
    GPSB_MODE_OUTPUT = 2'b10
  } gpsb_mode_t;

  // Per-pin configuration
  typedef struct packed {
    gpsb_mode_t mode;
    logic rise_en;
    logic fall_en;
    logic out_val;
  } gpsb_pin_cfg_t;

  // Card clock configuration
  typedef struct packed {
    logic en;
    logic [GPSB_DIV_W-1:0] div;
  } gpsb_clk_cfg_t;

endpackage : gpsb_pkg

// file: verilog/gpsb_clk_div.sv
// Programmable clock divider for card clock outputs
`timescale 1ns/100ps

module gpsb_clk_div
  import gpsb_pkg::*;
#(
  parameter int DIV_W = GPSB_DIV_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Configuration
  input wire logic en,
  input wire logic [DIV_W-1:0] div,
  // Clock out
  output logic clk_out
);

  logic [DIV_W-1:0] cnt_r;
  logic clk_r;

  //==============================================================
  // Half period is div+1 reference cycles; idle low when disabled
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        cnt_r <= '0;
        clk_r <= 1'b0;
      end else if (cnt_r >= div) begin // Reprogramming takes effect at once
        cnt_r <= '0;
        clk_r <= ~clk_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign clk_out = clk_r;

endmodule : gpsb_clk_div

// file: verilog/gpsb_top.sv
// General pin block with boot strap capture and card clocks
`timescale 1ns/100ps

module gpsb_top
  import gpsb_pkg::*;
#(
  parameter int NUM_PINS = GPSB_NUM_PINS,
  parameter int STRAP_IDX = GPSB_STRAP_IDX,
  parameter bit INSERT_ACTIVE_LOW = 1'b1
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Pins
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic strap_pull_up_en,
  // Pin configuration and status
  input wire gpsb_pin_cfg_t [NUM_PINS-1:0] pin_cfg,
  input wire logic [NUM_PINS-1:0] edge_clr,
  output logic [NUM_PINS-1:0] pin_input_status_one,
  output logic [NUM_PINS-1:0] edge_flag,
  output logic edge_irq,
  // Boot strap result
  output logic program_memory_select_bit,
  output logic strap_valid,
  // Card clocks
  input wire gpsb_clk_cfg_t stick_clk_cfg,
  input wire gpsb_clk_cfg_t card_clk_cfg,
  output logic stick_serial_clock,
  output logic card_bus_clock,
  // Card detect inputs and outputs
  input wire logic stick_insert_detect,
  input wire logic card_write_protect_in,
  output logic stick_card_present,
  output logic card_write_protect
);

  //==============================================================
  // Strap sequencing
  logic strap_cap_r;
  logic strap_done_r;
  logic [GPSB_PU_CNT_W-1:0] pu_cnt_r;
  logic pu_on_r;

  // Pull-up held by reset, dropped a few cycles after release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pu_on_r <= 1'b1;
      pu_cnt_r <= GPSB_PU_CNT_RST;
    end else if (ce && pu_on_r) begin
      if (pu_cnt_r == GPSB_PU_CNT_END - 1'b1) begin
        pu_on_r <= 1'b0;
      end
      pu_cnt_r <= pu_cnt_r + 1'b1;
    end
  end

  // Level taken at the first edge after release, pull-up still on
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_cap_r <= GPSB_STRAP_RST;
      strap_done_r <= 1'b0;
    end else if (ce && !strap_done_r) begin
      strap_cap_r <= pin_i[STRAP_IDX];
      strap_done_r <= 1'b1;
    end
  end

  assign strap_pull_up_en = pu_on_r;
  assign program_memory_select_bit = strap_cap_r; // 1 = internal code memory
  assign strap_valid = strap_done_r;

  //==============================================================
  // Input synchronisers and edge flags
  logic [NUM_PINS-1:0] sync1_r;
  logic [NUM_PINS-1:0] sync2_r;
  logic [NUM_PINS-1:0] prev_r;
  logic [NUM_PINS-1:0] flag_r;
  logic [NUM_PINS-1:0] rise;
  logic [NUM_PINS-1:0] fall;
  logic [NUM_PINS-1:0] hit;

  // Two stages before the status and edge logic look at the level; strap capture reads the raw pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else if (ce) begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  // Per-pin edge qualification and drive
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      // Strap pin stays undriven until its level has been taken and the pull-up is off
      logic drive_ok;
      assign drive_ok = (g != STRAP_IDX) || (strap_done_r && !pu_on_r);
      assign hit[g] = (pin_cfg[g].mode == GPSB_MODE_EDGE_IRQ) &&
                      ((pin_cfg[g].rise_en && rise[g]) ||
                       (pin_cfg[g].fall_en && fall[g]));
      assign pin_oe[g] = drive_ok && (pin_cfg[g].mode == GPSB_MODE_OUTPUT);
    end
  endgenerate

  // Sticky flags; a new edge in the clear cycle wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= '0;
    end else if (ce) begin
      flag_r <= (flag_r & ~edge_clr) | hit;
    end
  end

  // Output data registered so it never glitches on the pad
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_o <= '0;
    end else if (ce) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_o[i] <= pin_cfg[i].out_val;
      end
    end
  end

  assign pin_input_status_one = sync2_r;
  assign edge_flag = flag_r;
  assign edge_irq = |flag_r;

  //==============================================================
  // Card clocks
  gpsb_clk_div #(
    .DIV_W(GPSB_DIV_W)
  ) u_stick_div (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .en(stick_clk_cfg.en),
    .div(stick_clk_cfg.div),
    .clk_out(stick_serial_clock)
  );

  gpsb_clk_div #(
    .DIV_W(GPSB_DIV_W)
  ) u_card_div (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .en(card_clk_cfg.en),
    .div(card_clk_cfg.div),
    .clk_out(card_bus_clock)
  );

  //==============================================================
  // Card detect sampling
  logic [1:0] ins_sync_r;
  logic [1:0] wp_sync_r;
  logic present_r;
  logic wp_r;

  // Insert pin idles high on its pull-up, so low means inserted
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Start at the pin's idle level so release shows no false insertion
      ins_sync_r <= {INSERT_ACTIVE_LOW, INSERT_ACTIVE_LOW};
      wp_sync_r <= 2'h0;
      present_r <= 1'b0;
      wp_r <= 1'b0;
    end else if (ce) begin
      ins_sync_r <= {ins_sync_r[0], stick_insert_detect};
      wp_sync_r <= {wp_sync_r[0], card_write_protect_in};
      present_r <= ins_sync_r[1] ^ INSERT_ACTIVE_LOW;
      wp_r <= wp_sync_r[1];
    end
  end

  assign stick_card_present = present_r;
  assign card_write_protect = wp_r;

endmodule : gpsb_top

// file: testbench/gpsb_board.sv
// Board model: strap resistor, strap driver and a floating strap pin
`timescale 1ns/100ps
module gpsb_board (
  // Clock
  input wire logic ref_clk,
  // Device side
  input wire logic pull_up_en,
  input wire logic oe,
  input wire logic o,
  // Board driver
  input wire logic drv_en,
  input wire logic drv_val,
  // Pin level
  output logic lvl
);
  logic wander_r = 1'b0;
  // Floating pin wanders so a stale value never passes for a capture
  always @(posedge ref_clk) wander_r <= ~wander_r;
  // Device driver wins, then board driver, then the weak pull-up
  always_comb begin
    if (oe) lvl = o;
    else if (drv_en) lvl = drv_val;
    else if (pull_up_en) lvl = 1'b1;
    else lvl = wander_r;
  end
endmodule : gpsb_board

// file: testbench/gpsb_props.sv
// Port assertions for the general pin and strap block
`timescale 1ns/100ps
module gpsb_props
  import gpsb_pkg::*;
#(parameter int NUM_PINS = 8, parameter int STRAP_IDX = 6) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Pins and flags
  input wire logic [NUM_PINS-1:0] pin_i,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] edge_clr,
  input wire logic [NUM_PINS-1:0] pin_input_status_one,
  input wire logic [NUM_PINS-1:0] edge_flag,
  input wire logic edge_irq,
  // Strap and card side
  input wire logic strap_pull_up_en,
  input wire logic program_memory_select_bit,
  input wire logic strap_valid,
  input wire gpsb_clk_cfg_t stick_clk_cfg,
  input wire logic stick_serial_clock,
  input wire logic stick_insert_detect,
  input wire logic stick_card_present
);
  //==========
  // Checks; latencies assume ce held high
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_pu; $rose(strap_valid) |-> strap_pull_up_en[*3] ##1 !strap_pull_up_en; endproperty
  a_pu: assert property (p_pu) else $error("pull-up timing");
  property p_cap; $rose(strap_valid) |-> program_memory_select_bit == $past(pin_i[STRAP_IDX]);
  endproperty
  a_cap: assert property (p_cap) else $error("strap capture");
  property p_oe; strap_pull_up_en |-> !pin_oe[STRAP_IDX]; endproperty
  a_oe: assert property (p_oe) else $error("strap driven early");
  property p_sync; strap_valid && $past(strap_valid) |-> pin_input_status_one == $past(pin_i, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("status latency");
  property p_stick; ($past(edge_flag) & ~$past(edge_clr) & ~edge_flag) == '0; endproperty
  a_stick: assert property (p_stick) else $error("flag lost");
  property p_irq; edge_irq == |edge_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_off; !stick_clk_cfg.en |=> !stick_serial_clock; endproperty
  a_off: assert property (p_off) else $error("clock not stopped");
  property p_ins; strap_valid && $past(strap_valid, 2) |->
    stick_card_present == !$past(stick_insert_detect, 3); endproperty
  a_ins: assert property (p_ins) else $error("presence latency");
  cover property ($rose(edge_irq));
  cover property ($rose(strap_valid) ##1 !program_memory_select_bit);
  cover property ($rose(stick_card_present));
endmodule : gpsb_props
bind gpsb_top gpsb_props #(.NUM_PINS(NUM_PINS), .STRAP_IDX(STRAP_IDX)) gpsb_props_i (.*);

// file: testbench/tb_gpsb_top.sv
// Self-checking bench for the general pin and strap block
`timescale 1ns/100ps
module tb_gpsb_top;
  import gpsb_pkg::*;
  logic ref_clk = 0, arst_n = 0, ce = 1, d_en = 0, d_v = 0, ins = 1, wp = 0, l6;
  logic pu, sel, vld, irq, sc, cc, pres, wpo;
  logic [7:0] pi = '0, clr = '0, po, oe, st, fl;
  gpsb_pin_cfg_t [7:0] cfg = '0;
  gpsb_clk_cfg_t skc = '0, cdc = '0;
  int mismatches = 0, checks = 0, cyc = 0;
  gpsb_top gpsb_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce),
    .pin_i({pi[7], l6, pi[5:0]}), .pin_o(po), .pin_oe(oe), .strap_pull_up_en(pu),
    .pin_cfg(cfg), .edge_clr(clr), .pin_input_status_one(st), .edge_flag(fl),
    .edge_irq(irq), .program_memory_select_bit(sel), .strap_valid(vld),
    .stick_clk_cfg(skc), .card_clk_cfg(cdc), .stick_serial_clock(sc),
    .card_bus_clock(cc), .stick_insert_detect(ins), .card_write_protect_in(wp),
    .stick_card_present(pres), .card_write_protect(wpo));
  gpsb_board gpsb_board_i (.ref_clk(ref_clk), .pull_up_en(pu), .oe(oe[6]), .o(po[6]),
    .drv_en(d_en), .drv_val(d_v), .lvl(l6));
  //==========
  // Clock, hang guard and helpers
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      summarize();
    end
  end
  task step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task chk(string nm, logic [7:0] e, logic [7:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  //==========
  // Scenarios
  task t_boot(logic en, logic v, logic e);
    d_en = en;
    d_v = v;
    arst_n = 0;
    step(8);
    chk("pull_up", 1, pu);
    arst_n = 1;
    step(1);
    chk("present_idle", 0, pres);
    step(2);
    chk("select", e, sel);
    chk("pull_up_held", 1, pu);
    step(1);
    chk("pull_up_off", 0, pu);
  endtask : t_boot
  task t_edge;
    for (int k = 0; k < 8; k++) cfg[k] = '{GPSB_MODE_EDGE_IRQ, 1'b1, 1'b0, 1'b0};
    cfg[0].mode = GPSB_MODE_INPUT;
    d_v = 0;
    step(4);
    pi = 8'hff;
    d_v = 1;
    step(2);
    chk("status", 8'hff, st);
    chk("flags_early", 8'h00, fl);
    step(1);
    chk("flags", 8'hfe, fl);
    chk("irq", 1, irq);
    clr = 8'hff;
    step(1);
    clr = 8'h00;
    chk("flags_clr", 8'h00, fl);
    chk("irq_clr", 0, irq);
  endtask : t_edge
  task t_out;
    for (int k = 0; k < 8; k++) cfg[k] = '{GPSB_MODE_OUTPUT, 1'b0, 1'b0, k[0]};
    step(1);
    chk("oe", 8'hff, oe);
    chk("out", 8'haa, po);
  endtask : t_out
  task half(logic card, int e);
    int n;
    n = 0;
    @(posedge (card ? cc : sc));
    do begin
      step(1);
      n++;
    end while ((card ? cc : sc) === 1'b1);
    chk("half_period", e[7:0], n[7:0]);
  endtask : half
  task t_clk;
    skc = '{1'b1, 8'h01};
    cdc = '{1'b1, 8'h03};
    half(0, 2);
    half(1, 4);
    skc.en = 0;
    step(2);
    chk("stick_off", 0, sc);
  endtask : t_clk
  task t_ins;
    ins = 0;
    wp = 1;
    step(2);
    chk("present_early", 0, pres);
    chk("write_protect_early", 0, wpo);
    step(1);
    chk("present", 1, pres);
    chk("write_protect", 1, wpo);
  endtask : t_ins
  initial begin
    t_boot(0, 0, 1);
    t_boot(1, 0, 0);
    t_boot(1, 1, 1);
    t_edge();
    t_out();
    t_clk();
    t_ins();
    summarize();
  end
endmodule : tb_gpsb_top
